// ### rtl/atomic_cop_unit.sv
`timescale 1ns/1ps
`include "atomic_cop_defs.svh"
module atomic_cop_unit #(
  parameter int STATE_WORDS = `AC_STATE_WORDS
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // instruction command
  input  wire logic                  cmdValid,
  input  wire atomic_cop_pkg::op_t   cmdOp,
  input  wire atomic_cop_pkg::size_t cmdSize,
  input  wire logic                  cmdLong,
  input  wire logic [31:0]           cmdAddrA,
  input  wire logic [31:0]           cmdAddrB,
  input  wire logic [31:0]           cmdCmpA,
  input  wire logic [31:0]           cmdCmpB,
  input  wire logic [31:0]           cmdUpdA,
  input  wire logic [31:0]           cmdUpdB,
  input  wire logic [31:0]           cmdPc,
  input  wire logic [31:0]           cmdDisp,
  input  wire logic [4:0]            cmdCcr,
  // results
  output logic                       busy,
  output logic                       resDone,
  output logic [4:0]                 resCcr,
  output logic [31:0]                resPc,
  output logic [31:0]                resCmpA,
  output logic [31:0]                resCmpB,
  output logic [7:0]                 resSetByte,
  output logic                       resTrap,
  output logic [31:0]                resTrapData,
  // memory bus
  output logic                       memReq,
  output logic                       memWe,
  output logic [31:0]                memAddr,
  output logic [31:0]                memWdata,
  output atomic_cop_pkg::size_t      memSize,
  output logic                       memLock,
  input  wire logic                  memAck,
  input  wire logic [31:0]           memRdata,
  // coprocessor
  input  wire logic                  copCond,
  output logic                       copWordValid,
  output logic [31:0]                copWord,
  input  wire logic                  copAck,
  output logic                       copStateReq,
  input  wire logic                  copStateValid,
  input  wire logic [31:0]           copStateWord
);
  typedef struct packed {
    atomic_cop_pkg::state_t st;
    atomic_cop_pkg::op_t    op;
    atomic_cop_pkg::size_t  size;
    logic                   busy;
    logic                   done;
    logic                   lock;
    logic                   go;
    logic                   we;
    atomic_cop_pkg::size_t  bsize;
    logic [31:0]            addr;
    logic [31:0]            wdata;
    logic [31:0]            addrA;
    logic [31:0]            addrB;
    logic [31:0]            cmpA;
    logic [31:0]            cmpB;
    logic [31:0]            updA;
    logic [31:0]            updB;
    logic [31:0]            memA;
    logic [31:0]            memB;
    logic [4:0]             ccr;
    logic [31:0]            pc;
    logic [7:0]             setByte;
    logic                   trap;
    logic [31:0]            trapData;
    logic                   copValid;
    logic [31:0]            copWord;
    logic                   stateReq;
    logic [`AC_IDX_W-1:0]   idx;
  } unit_state_t;

  localparam logic [`AC_IDX_W-1:0] LAST_IDX = `AC_IDX_W'(STATE_WORDS - 1);

  unit_state_t s_r, s_nxt;
  mem_access_if acc ();

  bus_access_seq u_seq (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .acc      (acc),
    .memReq   (memReq),
    .memWe    (memWe),
    .memAddr  (memAddr),
    .memWdata (memWdata),
    .memSize  (memSize),
    .memAck   (memAck),
    .memRdata (memRdata)
  );

  // ==========
  // helpers
  function automatic logic [31:0] sizeMask(input atomic_cop_pkg::size_t z);
    unique case (z)
      atomic_cop_pkg::SZ_BYTE: sizeMask = 32'h000000FF;
      atomic_cop_pkg::SZ_WORD: sizeMask = 32'h0000FFFF;
      default:                 sizeMask = 32'hFFFFFFFF;
    endcase
  endfunction

  // flags of destination minus source, returned as N Z V C
  function automatic logic [3:0] cmpFlags(input logic [31:0] d,
                                          input logic [31:0] sv,
                                          input atomic_cop_pkg::size_t z);
    logic [31:0] r;
    logic        sm;
    logic        dm;
    logic        rm;
    r = (d - sv) & sizeMask(z);
    sm = (z == atomic_cop_pkg::SZ_BYTE) ? sv[7] :
         (z == atomic_cop_pkg::SZ_WORD) ? sv[15] : sv[31];
    dm = (z == atomic_cop_pkg::SZ_BYTE) ? d[7] :
         (z == atomic_cop_pkg::SZ_WORD) ? d[15] : d[31];
    rm = (z == atomic_cop_pkg::SZ_BYTE) ? r[7] :
         (z == atomic_cop_pkg::SZ_WORD) ? r[15] : r[31];
    cmpFlags = {rm, (r == 32'h0), (~sm & dm & ~rm) | (sm & ~dm & rm),
                (sm & ~dm) | (rm & ~dm) | (sm & rm)};
  endfunction

  function automatic logic [31:0] extDisp(input logic [31:0] v,
                                          input logic lng);
    extDisp = lng ? v : {{16{v[15]}}, v[15:0]};
  endfunction

  // ==========
  // controller
  logic [3:0]  fa;
  logic [3:0]  fb;
  logic [15:0] cnt;
  logic [7:0]  tb;

  always_comb begin
    s_nxt = s_r;
    s_nxt.go = 1'b0;
    s_nxt.done = 1'b0;
    fa = cmpFlags(s_r.memA, s_r.cmpA, s_r.size);
    fb = cmpFlags(s_r.memB, s_r.cmpB, s_r.size);
    cnt = cmdCmpA[15:0] - 16'h0001;
    tb = s_r.memA[7:0];
    unique case (s_r.st)
      atomic_cop_pkg::S_IDLE: if (cmdValid) begin
        s_nxt.busy  = 1'b1;
        s_nxt.op    = cmdOp;
        s_nxt.size  = cmdSize;
        s_nxt.addrA = cmdAddrA;
        s_nxt.addrB = cmdAddrB;
        s_nxt.cmpA  = cmdCmpA;
        s_nxt.cmpB  = cmdCmpB;
        s_nxt.updA  = cmdUpdA;
        s_nxt.updB  = cmdUpdB;
        s_nxt.pc    = cmdPc;
        s_nxt.ccr   = cmdCcr;
        s_nxt.trap  = 1'b0;
        s_nxt.idx   = '0;
        s_nxt.st    = atomic_cop_pkg::S_FINISH;
        unique case (cmdOp)
          atomic_cop_pkg::OP_CAS, atomic_cop_pkg::OP_DUAL_COMPARE_SWAP,
          atomic_cop_pkg::OP_TAS: begin
            // lock raised with the first read
            s_nxt.lock  = 1'b1;
            s_nxt.go    = 1'b1;
            s_nxt.we    = 1'b0;
            s_nxt.addr  = cmdAddrA;
            s_nxt.bsize = (cmdOp == atomic_cop_pkg::OP_TAS) ?
                          atomic_cop_pkg::SZ_BYTE : cmdSize;
            if (cmdOp == atomic_cop_pkg::OP_TAS)
              s_nxt.size = atomic_cop_pkg::SZ_BYTE;
            s_nxt.st    = atomic_cop_pkg::S_RDA;
          end
          atomic_cop_pkg::OP_BRANCH:
            if (copCond)
              s_nxt.pc = cmdPc + extDisp(cmdDisp, cmdLong);
          atomic_cop_pkg::OP_DBRANCH: if (!copCond) begin
            s_nxt.cmpA = {cmdCmpA[31:16], cnt};
            if (cnt != `AC_CNT_END)
              s_nxt.pc = cmdPc + extDisp(cmdDisp, 1'b0);
          end
          atomic_cop_pkg::OP_SETB:
            s_nxt.setByte = copCond ? `AC_BYTE_ONES : 8'h00;
          atomic_cop_pkg::OP_TRAP: begin
            s_nxt.trap     = copCond;
            s_nxt.trapData = extDisp(cmdDisp, cmdLong);
          end
          atomic_cop_pkg::OP_GEN: begin
            s_nxt.copValid = 1'b1;
            s_nxt.copWord  = cmdCmpA;
            s_nxt.st       = atomic_cop_pkg::S_COPOUT;
          end
          atomic_cop_pkg::OP_SAVE: begin
            s_nxt.stateReq = 1'b1;
            s_nxt.st       = atomic_cop_pkg::S_SAVEIN;
          end
          atomic_cop_pkg::OP_RESTORE: begin
            s_nxt.go    = 1'b1;
            s_nxt.we    = 1'b0;
            s_nxt.addr  = cmdAddrA;
            s_nxt.bsize = atomic_cop_pkg::SZ_LONG;
            s_nxt.st    = atomic_cop_pkg::S_RESTRD;
          end
          default: s_nxt.st = atomic_cop_pkg::S_FINISH;
        endcase
      end
      atomic_cop_pkg::S_RDA: if (acc.done) begin
        s_nxt.memA = acc.rdata & sizeMask(s_r.size);
        if (s_r.op == atomic_cop_pkg::OP_DUAL_COMPARE_SWAP) begin
          s_nxt.go   = 1'b1;
          s_nxt.addr = s_r.addrB;
          s_nxt.st   = atomic_cop_pkg::S_RDB;
        end else begin
          s_nxt.st = atomic_cop_pkg::S_EVAL;
        end
      end
      atomic_cop_pkg::S_RDB: if (acc.done) begin
        s_nxt.memB = acc.rdata & sizeMask(s_r.size);
        s_nxt.st   = atomic_cop_pkg::S_EVAL;
      end
      atomic_cop_pkg::S_EVAL: begin
        s_nxt.st = atomic_cop_pkg::S_FINISH;
        s_nxt.we = 1'b1;
        s_nxt.addr = s_r.addrA;
        if (s_r.op == atomic_cop_pkg::OP_TAS) begin
          s_nxt.ccr[3:0] = {tb[7], (tb == 8'h00), 2'b00};
          s_nxt.wdata    = {24'h0, tb | `AC_TAS_SET};
          s_nxt.go       = 1'b1;
          s_nxt.st       = atomic_cop_pkg::S_WRA;
        end else begin
          // extend bit stays as loaded
          s_nxt.ccr[3:0] = (s_r.op == atomic_cop_pkg::OP_DUAL_COMPARE_SWAP && fa[2]) ?
                           fb : fa;
          if (fa[2] && (s_r.op == atomic_cop_pkg::OP_CAS || fb[2])) begin
            s_nxt.wdata = s_r.updA & sizeMask(s_r.size);
            s_nxt.go    = 1'b1;
            s_nxt.st    = atomic_cop_pkg::S_WRA;
          end else begin
            // no write follows, so the lock ends with the last read
            s_nxt.cmpA = (s_r.cmpA & ~sizeMask(s_r.size)) | s_r.memA;
            if (s_r.op == atomic_cop_pkg::OP_DUAL_COMPARE_SWAP)
              s_nxt.cmpB = (s_r.cmpB & ~sizeMask(s_r.size)) | s_r.memB;
            s_nxt.lock = 1'b0;
          end
        end
      end
      atomic_cop_pkg::S_WRA: if (acc.done) begin
        if (s_r.op == atomic_cop_pkg::OP_DUAL_COMPARE_SWAP) begin
          s_nxt.go    = 1'b1;
          s_nxt.addr  = s_r.addrB;
          s_nxt.wdata = s_r.updB & sizeMask(s_r.size);
          s_nxt.st    = atomic_cop_pkg::S_WRB;
        end else begin
          s_nxt.lock = 1'b0;
          s_nxt.st   = atomic_cop_pkg::S_FINISH;
        end
      end
      atomic_cop_pkg::S_WRB: if (acc.done) begin
        s_nxt.lock = 1'b0;
        s_nxt.st   = atomic_cop_pkg::S_FINISH;
      end
      atomic_cop_pkg::S_COPOUT: if (copAck) begin
        s_nxt.copValid = 1'b0;
        s_nxt.st       = atomic_cop_pkg::S_FINISH;
        if (s_r.op == atomic_cop_pkg::OP_RESTORE && s_r.idx != LAST_IDX) begin
          s_nxt.idx  = s_r.idx + 1'b1;
          s_nxt.go   = 1'b1;
          s_nxt.addr = s_r.addrA + {22'h0, s_r.idx + 1'b1, 2'b00};
          s_nxt.st   = atomic_cop_pkg::S_RESTRD;
        end
      end
      atomic_cop_pkg::S_RESTRD: if (acc.done) begin
        s_nxt.copWord  = acc.rdata;
        s_nxt.copValid = 1'b1;
        s_nxt.st       = atomic_cop_pkg::S_COPOUT;
      end
      atomic_cop_pkg::S_SAVEIN: if (copStateValid) begin
        s_nxt.stateReq = 1'b0;
        s_nxt.go       = 1'b1;
        s_nxt.we       = 1'b1;
        s_nxt.bsize    = atomic_cop_pkg::SZ_LONG;
        s_nxt.wdata    = copStateWord;
        s_nxt.addr     = s_r.addrA + {22'h0, s_r.idx, 2'b00};
        s_nxt.st       = atomic_cop_pkg::S_SAVEWR;
      end
      atomic_cop_pkg::S_SAVEWR: if (acc.done) begin
        s_nxt.st = atomic_cop_pkg::S_FINISH;
        if (s_r.idx != LAST_IDX) begin
          s_nxt.idx      = s_r.idx + 1'b1;
          s_nxt.stateReq = 1'b1;
          s_nxt.st       = atomic_cop_pkg::S_SAVEIN;
        end
      end
      atomic_cop_pkg::S_FINISH: begin
        s_nxt.done = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.st   = atomic_cop_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========
  // outputs, all from the state register
  assign acc.go       = s_r.go;
  assign acc.we       = s_r.we;
  assign acc.addr     = s_r.addr;
  assign acc.wdata    = s_r.wdata;
  assign acc.size     = s_r.bsize;
  // other masters see the lock and hold off the location
  assign memLock      = s_r.lock;
  assign busy         = s_r.busy;
  assign resDone      = s_r.done;
  assign resCcr       = s_r.ccr;
  assign resPc        = s_r.pc;
  assign resCmpA      = s_r.cmpA;
  assign resCmpB      = s_r.cmpB;
  assign resSetByte   = s_r.setByte;
  assign resTrap      = s_r.trap;
  assign resTrapData  = s_r.trapData;
  assign copWordValid = s_r.copValid;
  assign copWord      = s_r.copWord;
  assign copStateReq  = s_r.stateReq;
endmodule // atomic_cop_unit

// ### rtl/atomic_cop_defs.svh
`ifndef ATOMIC_COP_DEFS_SVH
`define ATOMIC_COP_DEFS_SVH

// ==========
// widths and counts
`define AC_DATA_W      32
`define AC_STATE_WORDS 4
`define AC_IDX_W       8

// ==========
// condition code layout: extend, negative, zero, overflow, carry
`define AC_CC_X 4
`define AC_CC_N 3
`define AC_CC_Z 2
`define AC_CC_V 1
`define AC_CC_C 0

// ==========
// data constants
`define AC_TAS_SET   8'h80
`define AC_BYTE_ONES 8'hFF
`define AC_CNT_END   16'hFFFF
`define AC_RESET_CC  5'h00

`endif

// ### rtl/atomic_cop_pkg.sv
package atomic_cop_pkg;

  typedef enum logic [3:0] {
    OP_CAS, OP_DUAL_COMPARE_SWAP, OP_TAS, OP_BRANCH, OP_DBRANCH,
    OP_SETB, OP_TRAP, OP_GEN, OP_SAVE, OP_RESTORE
  } op_t;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_t;

  typedef enum logic [3:0] {
    S_IDLE, S_RDA, S_RDB, S_EVAL, S_WRA, S_WRB,
    S_COPOUT, S_SAVEIN, S_SAVEWR, S_RESTRD, S_FINISH
  } state_t;

  typedef struct packed {
    logic        busy;
    logic        req;
    logic        done;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    size_t       size;
    logic [31:0] rdata;
  } seq_state_t;

endpackage

// ### rtl/mem_access_if.sv
`timescale 1ns/1ps
interface mem_access_if;
  logic                      go;
  logic                      we;
  logic [31:0]               addr;
  logic [31:0]               wdata;
  atomic_cop_pkg::size_t     size;
  logic                      done;
  logic [31:0]               rdata;

  modport issuer (output go, we, addr, wdata, size, input done, rdata);
  modport server (input go, we, addr, wdata, size, output done, rdata);
endinterface

// ### rtl/bus_access_seq.sv
`timescale 1ns/1ps
module bus_access_seq (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // access requests from the controller
  mem_access_if.server               acc,
  // memory bus
  output logic                       memReq,
  output logic                       memWe,
  output logic [31:0]                memAddr,
  output logic [31:0]                memWdata,
  output atomic_cop_pkg::size_t      memSize,
  input  wire logic                  memAck,
  input  wire logic [31:0]           memRdata
);
  atomic_cop_pkg::seq_state_t s_r, s_nxt;

  // ==========
  // one bus access at a time; a new go while busy is dropped
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy && acc.go) begin
      s_nxt.busy  = 1'b1;
      s_nxt.req   = 1'b1;
      s_nxt.we    = acc.we;
      s_nxt.addr  = acc.addr;
      s_nxt.wdata = acc.wdata;
      s_nxt.size  = acc.size;
    end else if (s_r.req && memAck) begin
      s_nxt.busy  = 1'b0;
      s_nxt.req   = 1'b0;
      s_nxt.done  = 1'b1;
      s_nxt.rdata = memRdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_r <= '{busy: 1'b0, req: 1'b0, done: 1'b0, we: 1'b0,
               addr: 32'h0, wdata: 32'h0,
               size: atomic_cop_pkg::SZ_BYTE, rdata: 32'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign memReq    = s_r.req;
  assign memWe     = s_r.we;
  assign memAddr   = s_r.addr;
  assign memWdata  = s_r.wdata;
  assign memSize   = s_r.size;
  assign acc.done  = s_r.done;
  assign acc.rdata = s_r.rdata;
endmodule // bus_access_seq

// ### testbench/atomic_cop_assertions.sv
`timescale 1ns/1ps
module atomic_cop_assertions #(
  parameter int STATE_WORDS = 4
) (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  reset,
  // command
  input wire logic                  cmdValid,
  input wire atomic_cop_pkg::op_t   cmdOp,
  input wire logic                  cmdLong,
  input wire logic [31:0]           cmdCmpA,
  input wire logic [31:0]           cmdPc,
  input wire logic [31:0]           cmdDisp,
  input wire logic [4:0]            cmdCcr,
  input wire logic                  copCond,
  // results
  input wire logic                  busy,
  input wire logic                  resDone,
  input wire logic [4:0]            resCcr,
  input wire logic [31:0]           resPc,
  input wire logic [31:0]           resCmpA,
  input wire logic [7:0]            resSetByte,
  input wire logic                  resTrap,
  // memory bus
  input wire logic                  memReq,
  input wire logic                  memWe,
  input wire logic [31:0]           memWdata,
  input wire atomic_cop_pkg::size_t memSize,
  input wire logic                  memLock,
  input wire logic                  memAck
);
  // ==========
  // command seen at take, so results can be tied to it
  atomic_cop_pkg::op_t opR;
  logic                condR;
  logic [31:0]         pcR;
  logic [31:0]         dispR;
  logic [15:0]         cntR;
  logic [4:0]          ccrR;
  always_ff @(posedge ref_clk) begin
    if (cmdValid && !busy) begin
      opR   <= cmdOp;
      condR <= copCond;
      pcR   <= cmdPc;
      cntR  <= cmdCmpA[15:0];
      ccrR  <= cmdCcr;
      dispR <= (cmdLong && cmdOp != atomic_cop_pkg::OP_DBRANCH) ? cmdDisp
               : {{16{cmdDisp[15]}}, cmdDisp[15:0]};
    end
  end

  // ==========
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence seqEnd(atomic_cop_pkg::op_t op);
    resDone && opR == op;
  endsequence
  sequence seqAtomicAccess;
    memReq && busy && opR inside {atomic_cop_pkg::OP_CAS,
      atomic_cop_pkg::OP_DUAL_COMPARE_SWAP, atomic_cop_pkg::OP_TAS};
  endsequence

  a_branch_target: assert property (
    seqEnd(atomic_cop_pkg::OP_BRANCH) |-> resPc == (condR ? pcR + dispR : pcR)
  ) else $error("branch target wrong");
  a_dbranch_count: assert property (
    seqEnd(atomic_cop_pkg::OP_DBRANCH) ##0 !condR
      |-> resCmpA[15:0] == cntR - 16'h0001
  ) else $error("decrement count wrong");
  a_dbranch_exit: assert property (
    seqEnd(atomic_cop_pkg::OP_DBRANCH)
      |-> resPc == ((!condR && cntR != 16'h0000) ? pcR + dispR : pcR)
  ) else $error("decrement branch target wrong");
  a_set_byte: assert property (
    seqEnd(atomic_cop_pkg::OP_SETB) |-> resSetByte == {8{condR}}
  ) else $error("set byte wrong");
  a_trap_cond: assert property (
    seqEnd(atomic_cop_pkg::OP_TRAP) |-> resTrap == condR
  ) else $error("trap flag wrong");
  a_tas_write: assert property (
    memReq && memWe && busy && opR == atomic_cop_pkg::OP_TAS
      |-> memWdata[7] && memSize == atomic_cop_pkg::SZ_BYTE && memLock
  ) else $error("tas write wrong");
  a_tas_flags: assert property (
    seqEnd(atomic_cop_pkg::OP_TAS)
      |-> resCcr[4] == ccrR[4] && resCcr[1:0] == 2'b00
  ) else $error("tas flags wrong");
  a_swap_extend: assert property (
    resDone && (opR == atomic_cop_pkg::OP_CAS || opR == atomic_cop_pkg::OP_DUAL_COMPARE_SWAP)
      |-> resCcr[4] == ccrR[4]
  ) else $error("swap extend flag changed");
  a_atomic_locked: assert property (
    seqAtomicAccess |-> memLock
  ) else $error("atomic access not locked");
  a_lock_release: assert property (
    $fell(memLock) && !$past(reset) |-> $past(memAck, 2) || $past(memAck, 3)
  ) else $error("lock dropped early");
endmodule // atomic_cop_assertions

bind atomic_cop_unit atomic_cop_assertions #(.STATE_WORDS(STATE_WORDS)) chk (
  .ref_clk, .reset, .cmdValid, .cmdOp, .cmdLong, .cmdCmpA, .cmdPc,
  .cmdDisp, .cmdCcr, .copCond, .busy, .resDone, .resCcr, .resPc,
  .resCmpA, .resSetByte, .resTrap, .memReq, .memWe, .memWdata,
  .memSize, .memLock, .memAck
);

// ### testbench/mem_cop_model.sv
`timescale 1ns/1ps
module mem_cop_model (
  // clock, reset, pacing
  input wire logic                  ref_clk,
  input wire logic                  reset,
  input wire logic                  slow,
  // memory bus
  input wire logic                  memReq,
  input wire logic                  memWe,
  input wire logic [31:0]           memAddr,
  input wire logic [31:0]           memWdata,
  input wire atomic_cop_pkg::size_t memSize,
  output logic                      memAck = 1'b0,
  output logic [31:0]               memRdata = 32'h3C3C5A5A,
  // coprocessor
  input wire logic                  copWordValid,
  input wire logic [31:0]           copWord,
  output logic                      copAck = 1'b0,
  input wire logic                  copStateReq,
  output logic                      copStateValid = 1'b0,
  output logic [31:0]               copStateWord = 32'h0F0F0F0F
);
  logic [31:0] mem [0:63];
  logic [31:0] copRx [0:7];
  logic [2:0]  rxCnt = 3'h0;
  logic [2:0]  stCnt = 3'h0;
  logic [1:0]  dly = 2'h0;
  logic [31:0] m;
  logic [5:0]  idx;
  assign m   = memSize == atomic_cop_pkg::SZ_BYTE ? 32'h000000FF :
               memSize == atomic_cop_pkg::SZ_WORD ? 32'h0000FFFF : 32'hFFFFFFFF;
  assign idx = memAddr[7:2];

  // ==========
  // idle data lines never repeat the last value
  always @(posedge ref_clk) begin
    memAck        <= 1'b0;
    copAck        <= 1'b0;
    copStateValid <= 1'b0;
    memRdata      <= ~memRdata;
    copStateWord  <= ~copStateWord;
    if (reset) begin
      dly   <= 2'h0;
      rxCnt <= 3'h0;
      stCnt <= 3'h0;
    end else if (dly < (slow ? 2'h3 : 2'h0)) begin
      if ((memReq && !memAck) || (copWordValid && !copAck)
          || (copStateReq && !copStateValid)) begin
        dly <= dly + 2'h1;
      end
    end else if (memReq && !memAck) begin
      // only one requester here, so nothing slips into a locked swap
      memAck   <= 1'b1;
      dly      <= 2'h0;
      memRdata <= (mem[idx] & m) | (~m & 32'hA5A5A5A5);
      if (memWe) begin
        mem[idx] <= (mem[idx] & ~m) | (memWdata & m);
      end
    end else if (copWordValid && !copAck) begin
      copAck       <= 1'b1;
      copRx[rxCnt] <= copWord;
      rxCnt        <= rxCnt + 3'h1;
      dly          <= 2'h0;
    end else if (copStateReq && !copStateValid) begin
      copStateValid <= 1'b1;
      copStateWord  <= 32'h5EED0000 + {29'h0, stCnt};
      stCnt         <= stCnt + 3'h1;
      dly           <= 2'h0;
    end
  end
endmodule // mem_cop_model

// ### testbench/atomic_cop_unit_test.sv
`timescale 1ns/1ps
module atomic_cop_unit_test;
  typedef struct packed {
    atomic_cop_pkg::op_t   op;
    atomic_cop_pkg::size_t size;
    logic                  lng;
    logic                  cond;
    logic [31:0]           addrA;
    logic [31:0]           addrB;
    logic [31:0]           cmpA;
    logic [31:0]           cmpB;
    logic [31:0]           updA;
    logic [31:0]           updB;
    logic [31:0]           pc;
    logic [31:0]           disp;
    logic [4:0]            ccr;
  } cmd_t;
  typedef struct packed {
    cmd_t        c;
    logic [31:0] exp;
  } row_t;

  logic                  ref_clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  slow = 1'b0;
  logic                  cmdValid = 1'b0;
  cmd_t                  cmd = '0;
  cmd_t                  c;
  row_t                  rows [0:6];
  int                    nFail = 0;
  int                    samplesChecked = 0;
  logic                  busy, resDone, resTrap, memReq, memWe, memLock;
  logic                  memAck, copWordValid, copAck, copStateReq;
  logic                  copStateValid;
  logic [4:0]            resCcr;
  logic [7:0]            resSetByte;
  logic [31:0]           resPc, resCmpA, memAddr, memWdata, memRdata;
  logic [31:0]           copWord, copStateWord, resCmpB, resTrapData;
  atomic_cop_pkg::size_t memSize;

  always #12.5 ref_clk = ~ref_clk;

  atomic_cop_unit dut (
    .ref_clk, .reset, .cmdValid, .cmdOp(cmd.op), .cmdSize(cmd.size),
    .cmdLong(cmd.lng), .cmdAddrA(cmd.addrA), .cmdAddrB(cmd.addrB),
    .cmdCmpA(cmd.cmpA), .cmdCmpB(cmd.cmpB), .cmdUpdA(cmd.updA),
    .cmdUpdB(cmd.updB), .cmdPc(cmd.pc), .cmdDisp(cmd.disp),
    .cmdCcr(cmd.ccr), .busy, .resDone, .resCcr, .resPc, .resCmpA,
    .resCmpB, .resSetByte, .resTrap, .resTrapData, .memReq, .memWe,
    .memAddr, .memWdata, .memSize, .memLock, .memAck, .memRdata,
    .copCond(cmd.cond), .copWordValid, .copWord, .copAck, .copStateReq,
    .copStateValid, .copStateWord
  );
  mem_cop_model model (
    .ref_clk, .reset, .slow, .memReq, .memWe, .memAddr, .memWdata,
    .memSize, .memAck, .memRdata, .copWordValid, .copWord, .copAck,
    .copStateReq, .copStateValid, .copStateWord
  );

  // ==========
  // helpers
  task automatic reportAndStop();
    $display("comparisons %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic cmd_t mk(input atomic_cop_pkg::op_t op,
      input logic cond, input logic lng, input logic [31:0] disp);
    mk = '{op: op, cond: cond, lng: lng, disp: disp, pc: 32'h00001000,
           size: atomic_cop_pkg::SZ_LONG, default: '0};
  endfunction
  task automatic runCmd(input cmd_t x);
    int i;
    @(negedge ref_clk);
    cmd      = x;
    cmdValid = 1'b1;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    for (i = 0; i < 300 && resDone !== 1'b1; i++) @(negedge ref_clk);
    if (resDone !== 1'b1) begin
      nFail++;
      reportAndStop();
    end
  endtask

  // ==========
  // main sequence
  initial begin
    rows = '{
      '{mk(atomic_cop_pkg::OP_BRANCH, 1, 0, 32'h0000FFF0), 32'h00000FF0},
      '{mk(atomic_cop_pkg::OP_BRANCH, 0, 0, 32'h0000FFF0), 32'h00001000},
      '{mk(atomic_cop_pkg::OP_BRANCH, 1, 1, 32'h00020000), 32'h00021000},
      '{mk(atomic_cop_pkg::OP_SETB, 1, 0, 32'h0), 32'h000000FF},
      '{mk(atomic_cop_pkg::OP_SETB, 0, 0, 32'h0), 32'h00000000},
      '{mk(atomic_cop_pkg::OP_TRAP, 1, 1, 32'h12345678), 32'h00000001},
      '{mk(atomic_cop_pkg::OP_TRAP, 0, 0, 32'hFFFF8000), 32'h00000000}};
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    check({busy, resDone, memReq, memLock, copWordValid, copStateReq}, 0);
    $display("test reset done");
    foreach (rows[i]) begin
      runCmd(rows[i].c);
      check(rows[i].c.op == atomic_cop_pkg::OP_BRANCH ? resPc :
            rows[i].c.op == atomic_cop_pkg::OP_SETB ? {24'h0, resSetByte}
            : {31'h0, resTrap}, rows[i].exp);
    end
    check(resTrapData, 32'hFFFF8000);
    $display("test table done");
    for (int k = 0; k < 2; k++) begin
      c      = mk(atomic_cop_pkg::OP_DBRANCH, 0, 0, 32'h00000010);
      c.cmpA = k ? 32'hABCD0005 : 32'hABCD0000;
      runCmd(c);
      check(resCmpA[15:0], k ? 16'h0004 : 16'hFFFF);
      check(resPc, k ? 32'h00001010 : 32'h00001000);
    end
    $display("test count branch done");
    slow = 1'b1;
    model.mem[4] = 32'h12345678;
    c = mk(atomic_cop_pkg::OP_CAS, 0, 0, 32'h0);
    c.addrA = 32'h10;
    c.cmpA  = 32'h12345678;
    c.updA  = 32'hCAFEF00D;
    c.ccr   = 5'h10;
    runCmd(c);
    check(model.mem[4], 32'hCAFEF00D);
    check(resCcr, 5'h14);
    slow = 1'b0;
    model.mem[5] = 32'h77777755;
    c.addrA = 32'h14;
    c.size  = atomic_cop_pkg::SZ_BYTE;
    c.cmpA  = 32'h60;
    c.ccr   = 5'h00;
    runCmd(c);
    check(model.mem[5], 32'h77777755);
    check(resCmpA[7:0], 8'h55);
    check(resCcr, 5'h09);
    model.mem[6] = 32'h1111;
    model.mem[7] = 32'h2222;
    c = mk(atomic_cop_pkg::OP_DUAL_COMPARE_SWAP, 0, 0, 32'h0);
    c.size  = atomic_cop_pkg::SZ_WORD;
    c.addrA = 32'h18;
    c.addrB = 32'h1C;
    c.cmpA  = 32'h1111;
    c.cmpB  = 32'h2222;
    c.updA  = 32'hAAAA;
    c.updB  = 32'hBBBB;
    runCmd(c);
    check(model.mem[6], 32'hAAAA);
    check(model.mem[7], 32'hBBBB);
    check(resCmpB, 32'h2222);
    check(resCcr, 5'h04);
    $display("test swap done");
    model.mem[8] = 32'h0;
    for (int k = 0; k < 2; k++) begin
      c = mk(atomic_cop_pkg::OP_TAS, 0, 0, 32'h0);
      c.addrA = 32'h20;
      c.ccr   = 5'h13;
      runCmd(c);
      check(model.mem[8], 32'h80);
      check(resCcr, k ? 5'h18 : 5'h14);
    end
    $display("test tas done");
    slow = 1'b1;
    c = mk(atomic_cop_pkg::OP_GEN, 0, 0, 32'h0);
    c.cmpA = 32'hC0DE0001;
    runCmd(c);
    check(model.copRx[0], 32'hC0DE0001);
    c = mk(atomic_cop_pkg::OP_SAVE, 0, 0, 32'h0);
    c.addrA = 32'h40;
    runCmd(c);
    for (int i = 0; i < 4; i++) begin
      check(model.mem[16+i], 32'h5EED0000 + i);
      model.mem[24+i] = 32'hBEEF0000 + i;
    end
    c = mk(atomic_cop_pkg::OP_RESTORE, 0, 0, 32'h0);
    c.addrA = 32'h60;
    runCmd(c);
    for (int i = 0; i < 4; i++) begin
      check(model.copRx[1+i], 32'hBEEF0000 + i);
    end
    $display("test coprocessor done");
    reportAndStop();
  end
endmodule // atomic_cop_unit_test
